// [design/cmr_pkg.sv]
`default_nettype none

// ==========================================================
// Shared constants of the converter misc register group
// ==========================================================
package cmr_pkg;

  // Serial frame layout: one direction bit, then the address
  localparam int unsigned ADDR_W   = 15;
  localparam int unsigned DATA_W   = 8;
  localparam logic [3:0]  CMD_LAST = 4'hf;
  localparam logic [3:0]  BYTE_LAST = 4'h7;

  // Register byte addresses, low byte at the lowest address
  localparam logic [14:0] ADDR_POS_B0 = 15'h002c;
  localparam logic [14:0] ADDR_POS_B1 = 15'h002d;
  localparam logic [14:0] ADDR_POS_B2 = 15'h002e;
  localparam logic [14:0] ADDR_FS_LO  = 15'h0030;
  localparam logic [14:0] ADDR_FS_HI  = 15'h0031;
  localparam logic [14:0] ADDR_PP1    = 15'h0037;
  localparam logic [14:0] ADDR_TSC    = 15'h003b;
  localparam logic [14:0] ADDR_REFO   = 15'h003c;

  // Reset values
  localparam logic [23:0] RST_POS   = 24'h000000;
  localparam logic [15:0] RST_FS    = 16'ha000;
  localparam logic [7:0]  RST_PP1   = 8'h4b;
  localparam logic [7:0]  RST_TSC   = 8'h00;
  localparam logic [7:0]  RST_REFO  = 8'h01;
  localparam logic [3:0]  RST_DELAY = 4'h0;

  // Power profile codes
  localparam logic [7:0] PP_LOW_POWER = 8'h46;
  localparam logic [7:0] PP_HIGH_PERF = 8'h4b;

  // Field positions
  localparam int unsigned TSC_RX_BIT   = 0;
  localparam int unsigned TSC_PECL_BIT = 1;
  localparam int unsigned REFO_EN_BIT  = 0;

endpackage : cmr_pkg

`default_nettype wire

// [design/cmr_reg_if.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Byte access path between serial port and register bank
// ==========================================================
interface cmr_reg_if;
  logic        wr_stb;   // One-cycle write pulse
  logic [14:0] wr_addr;
  logic [7:0]  wr_data;
  logic [14:0] rd_addr;  // Address of the byte to be shifted out
  logic [7:0]  rd_data;
  logic        sdo;
  logic        sdo_oe;

  modport port (
    output wr_stb, wr_addr, wr_data, rd_addr, sdo, sdo_oe,
    input  rd_data
  );
  modport regs (
    input  wr_stb, wr_addr, wr_data, rd_addr, sdo, sdo_oe,
    output rd_data
  );
endinterface : cmr_reg_if

`default_nettype wire

// [design/cmr_serial_port.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Serial host port: mode 0, MSB first, auto-incrementing address
// ==========================================================
module cmr_serial_port (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Serial pins, already synchronous to clk_i
  input  wire logic sclk_i,
  input  wire logic scs_n_i,
  input  wire logic sdi_i,
  // Byte path to the register bank
  cmr_reg_if.port   bus
);

  typedef enum logic {ST_CMD, ST_DATA} cmr_spi_state_t;

  cmr_spi_state_t state;
  logic           sclk_q;
  logic [3:0]     bit_cnt;
  logic [15:0]    shift;
  logic           is_read;
  logic           load_pend;
  logic [14:0]    addr;
  logic [7:0]     sdo_sh;
  logic           rise;
  logic           fall;

  // ==========================================================
  // Edge detection on the serial clock
  // ==========================================================
  // Edges only count while selected; stray clocks are ignored
  assign rise = !scs_n_i && sclk_i && !sclk_q;
  assign fall = !scs_n_i && !sclk_i && sclk_q;
  assign bus.rd_addr = addr;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk_i;
  end

  // ==========================================================
  // Frame decode: command word, then data bytes
  // ==========================================================
  // Chip select high aborts any partial byte without writing it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state       <= ST_CMD;
      bit_cnt     <= 4'h0;
      shift       <= 16'h0000;
      is_read     <= 1'b0;
      load_pend   <= 1'b0;
      addr        <= 15'h0000;
      bus.wr_stb  <= 1'b0;
      bus.wr_addr <= 15'h0000;
      bus.wr_data <= 8'h00;
    end
    else
    begin
      load_pend  <= 1'b0;
      bus.wr_stb <= 1'b0;
      if (scs_n_i)
      begin
        state   <= ST_CMD;
        bit_cnt <= 4'h0;
      end
      else if (rise)
      begin
        shift   <= {shift[14:0], sdi_i};
        bit_cnt <= bit_cnt + 4'h1;
        unique case (state)
          ST_CMD:
          begin
            if (bit_cnt == 4'h0)
              is_read <= sdi_i;
            if (bit_cnt == cmr_pkg::CMD_LAST)
            begin
              addr      <= {shift[13:0], sdi_i};
              state     <= ST_DATA;
              bit_cnt   <= 4'h0;
              load_pend <= is_read;
            end
          end
          ST_DATA:
          begin
            if (bit_cnt == cmr_pkg::BYTE_LAST)
            begin
              bit_cnt     <= 4'h0;
              addr        <= addr + 15'h0001;
              load_pend   <= is_read;
              bus.wr_stb  <= !is_read;
              bus.wr_addr <= addr;
              bus.wr_data <= {shift[6:0], sdi_i};
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Read data shifter, changes on the falling serial edge
  // ==========================================================
  // Loaded a cycle after the address settles, long before the next fall
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sdo_sh     <= 8'h00;
      bus.sdo    <= 1'b0;
      bus.sdo_oe <= 1'b0;
    end
    else if (scs_n_i)
    begin
      bus.sdo_oe <= 1'b0;
    end
    else if (load_pend)
    begin
      sdo_sh <= bus.rd_data;
    end
    else if (fall)
    begin
      bus.sdo    <= sdo_sh[7];
      sdo_sh     <= {sdo_sh[6:0], 1'b0};
      bus.sdo_oe <= is_read && (state == ST_DATA);
    end
  end

endmodule // cmr_serial_port

`default_nettype wire

// [design/cmr_misc_regs.sv]
`timescale 1ns/10ps
`default_nettype none

module cmr_misc_regs (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // Serial host port
  input  wire logic        SCLK_I,
  input  wire logic        SCS_N_I,
  input  wire logic        SDI_I,
  output logic             SDO_O,
  output logic             SDO_OE_O,
  // Alignment pulse capture
  input  wire logic [23:0] ALIGN_EDGE_POS_I,
  input  wire logic [3:0]  ALIGN_DELAY_SEL_I,
  output logic      [3:0]  ALIGN_CAPTURE_DELAY_O,
  // Analog settings
  output logic      [15:0] FULL_SCALE_O,
  output logic             POWER_LOW_MODE_O,
  output logic             POWER_HIGH_PERF_O,
  // Timestamp input receiver
  output logic             TSTAMP_RX_EN_O,
  output logic             TSTAMP_PECL_MODE_O,
  // Reference clock output
  input  wire logic        PLL_EN_I,
  output logic             REFCLK_OUT_EN_O
);

  logic        rst_meta;
  logic        rst_sync;
  logic [23:0] edge_pos;
  logic [15:0] full_scale;
  logic [7:0]  profile_code;
  logic [7:0]  tstamp_ctrl;
  logic [7:0]  refo_ctrl;
  logic [7:0]  next_rd_data;

  cmr_reg_if bus ();

  // ==========================================================
  // Reset release through two flops
  // ==========================================================
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // Serial port
  // ==========================================================
  cmr_serial_port u_port (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_sync),
    .sclk_i  (SCLK_I),
    .scs_n_i (SCS_N_I),
    .sdi_i   (SDI_I),
    .bus     (bus.port)
  );

  assign SDO_O    = bus.sdo;
  assign SDO_OE_O = bus.sdo_oe;

  // ==========================================================
  // Status capture
  // ==========================================================
  // Sampled every cycle; host writes never reach it
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      edge_pos <= cmr_pkg::RST_POS;
    else
      edge_pos <= ALIGN_EDGE_POS_I;
  end

  // Delay choice is owned upstream; registered here for a clean output
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      ALIGN_CAPTURE_DELAY_O <= cmr_pkg::RST_DELAY;
    else
      ALIGN_CAPTURE_DELAY_O <= ALIGN_DELAY_SEL_I;
  end

  // ==========================================================
  // Writable registers
  // ==========================================================
  // Full scale, one byte per address, all channels at once
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      full_scale <= cmr_pkg::RST_FS;
    else if (bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_FS_LO)
      full_scale[7:0] <= bus.wr_data;
    else if (bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_FS_HI)
      full_scale[15:8] <= bus.wr_data;
  end

  // Profile code stored whole, reserved codes included
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      profile_code <= cmr_pkg::RST_PP1;
    else if (bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_PP1)
      profile_code <= bus.wr_data;
  end

  // Reserved bits kept so they read back as written
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      tstamp_ctrl <= cmr_pkg::RST_TSC;
    else if (bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_TSC)
      tstamp_ctrl <= bus.wr_data;
  end

  // Enable on from reset: this clock may feed the host's serial clock
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      refo_ctrl <= cmr_pkg::RST_REFO;
    else if (bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_REFO)
      refo_ctrl <= bus.wr_data;
  end

  assign FULL_SCALE_O = full_scale;

  // ==========================================================
  // Decoded controls
  // ==========================================================
  // Reserved profile codes assert neither mode
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      POWER_LOW_MODE_O  <= 1'b0;
      POWER_HIGH_PERF_O <= 1'b0;
    end
    else
    begin
      POWER_LOW_MODE_O  <= (profile_code == cmr_pkg::PP_LOW_POWER);
      POWER_HIGH_PERF_O <= (profile_code == cmr_pkg::PP_HIGH_PERF);
    end
  end

  // Timestamp receiver controls
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      TSTAMP_RX_EN_O     <= 1'b0;
      TSTAMP_PECL_MODE_O <= 1'b0;
    end
    else
    begin
      TSTAMP_RX_EN_O     <= tstamp_ctrl[cmr_pkg::TSC_RX_BIT];
      TSTAMP_PECL_MODE_O <= tstamp_ctrl[cmr_pkg::TSC_PECL_BIT];
    end
  end

  // Output gated by the synthesizer so it never runs unlocked
  always_ff @(posedge CLK_SYS_I or negedge rst_sync)
  begin
    if (!rst_sync)
      REFCLK_OUT_EN_O <= 1'b0;
    else
      REFCLK_OUT_EN_O <= refo_ctrl[cmr_pkg::REFO_EN_BIT] && PLL_EN_I;
  end

  // ==========================================================
  // Read mux
  // ==========================================================
  // Unmapped addresses read as zero
  always_comb
  begin
    next_rd_data = 8'h00;
    unique case (bus.rd_addr)
      cmr_pkg::ADDR_POS_B0: next_rd_data = edge_pos[7:0];
      cmr_pkg::ADDR_POS_B1: next_rd_data = edge_pos[15:8];
      cmr_pkg::ADDR_POS_B2: next_rd_data = edge_pos[23:16];
      cmr_pkg::ADDR_FS_LO:  next_rd_data = full_scale[7:0];
      cmr_pkg::ADDR_FS_HI:  next_rd_data = full_scale[15:8];
      cmr_pkg::ADDR_PP1:    next_rd_data = profile_code;
      cmr_pkg::ADDR_TSC:    next_rd_data = tstamp_ctrl;
      cmr_pkg::ADDR_REFO:   next_rd_data = refo_ctrl;
      default:              next_rd_data = 8'h00;
    endcase
  end

  assign bus.rd_data = next_rd_data;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!rst_sync);

  property p_pos_read;
    bus.rd_addr == cmr_pkg::ADDR_POS_B2 |-> bus.rd_data == $past(ALIGN_EDGE_POS_I[23:16]);
  endproperty
  a_pos_read: assert property (p_pos_read) else $error("edge position read wrong");

  property p_pos_no_write;
    bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_POS_B0 |=> edge_pos == $past(ALIGN_EDGE_POS_I);
  endproperty
  a_pos_no_write: assert property (p_pos_no_write) else $error("status took a write");

  property p_delay;
    ##1 ALIGN_CAPTURE_DELAY_O == $past(ALIGN_DELAY_SEL_I);
  endproperty
  a_delay: assert property (p_delay) else $error("delay select not applied");

  property p_fs_hi;
    bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_FS_HI
      |=> FULL_SCALE_O[15:8] == $past(bus.wr_data) && $stable(FULL_SCALE_O[7:0]);
  endproperty
  a_fs_hi: assert property (p_fs_hi) else $error("full scale high byte wrong");

  property p_profile;
    bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_PP1 && bus.wr_data == cmr_pkg::PP_LOW_POWER
      |=> ##1 POWER_LOW_MODE_O && !POWER_HIGH_PERF_O;
  endproperty
  a_profile: assert property (p_profile) else $error("low power code not decoded");

  property p_profile_rsvd;
    profile_code != cmr_pkg::PP_LOW_POWER && profile_code != cmr_pkg::PP_HIGH_PERF
      |=> !POWER_LOW_MODE_O && !POWER_HIGH_PERF_O;
  endproperty
  a_profile_rsvd: assert property (p_profile_rsvd) else $error("reserved code decoded");

  property p_ts_rx;
    bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_TSC
      |=> ##1 TSTAMP_RX_EN_O == $past(bus.wr_data[0], 2);
  endproperty
  a_ts_rx: assert property (p_ts_rx) else $error("timestamp receiver enable wrong");

  property p_ts_pecl;
    bus.wr_stb && bus.wr_addr == cmr_pkg::ADDR_TSC
      |=> ##1 TSTAMP_PECL_MODE_O == $past(bus.wr_data[1], 2);
  endproperty
  a_ts_pecl: assert property (p_ts_pecl) else $error("timestamp PECL mode wrong");

  property p_refo;
    !PLL_EN_I |=> !REFCLK_OUT_EN_O;
  endproperty
  a_refo: assert property (p_refo) else $error("reference output without synthesizer");

  property p_refo_reset;
    $rose(rst_sync) ##0 PLL_EN_I [*2] |-> ##1 REFCLK_OUT_EN_O;
  endproperty
  a_refo_reset: assert property (p_refo_reset) else $error("reference output off after reset");

endmodule // cmr_misc_regs

`default_nettype wire

// [test/cmr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host side of the serial port
// ==========================================================
module cmr_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      sclk_o,
  output logic      scs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic oe_bad;  // Drive enable wrong at a sampled bit

  // Idle bus: clock low, deselected
  initial
  begin
    sclk_o  = 1'b0;
    scs_n_o = 1'b1;
    sdi_o   = 1'b0;
    oe_bad  = 1'b0;
  end

  // One bit, 5 cycles each phase, above the 4-cycle minimum
  task automatic shift_bit(input logic b, input logic rd, output logic r);
    sdi_o <= b;
    repeat (5) @(posedge clk_i);
    sclk_o <= 1'b1;
    r = sdo_i;
    // Enable must be up on read data bits and down on every other sampled bit
    if (sdo_oe_i !== rd)
      oe_bad = 1'b1;
    repeat (5) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask

  // Frame of n bytes from a, byte k at a+k in wd/q bits 8k+7..8k
  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [31:0] wd, output logic [31:0] q);
    logic [15:0] hdr;
    logic        r;
    hdr = {rd, a};
    q   = 32'h0;
    @(posedge clk_i);
    scs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
      shift_bit(hdr[i], 1'b0, r);
    for (int k = 0; k < n; k++)
      for (int i = 7; i >= 0; i--)
      begin
        shift_bit(wd[8*k+i], rd, r);
        q[8*k+i] = r;
      end
    repeat (2) @(posedge clk_i);
    scs_n_o <= 1'b1;
    sdi_o   <= ~sdi_o;  // Released line must not show a stale bit
    repeat (2) @(posedge clk_i);
  endtask
endmodule // cmr_host_model

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clk;
  logic        rst_n;
  logic        sclk, scs_n, sdi, sdo, sdo_oe;
  logic [23:0] edge_pos;
  logic [3:0]  dly_sel;
  logic [3:0]  cap_dly;
  logic [15:0] fs;
  logic        low_pw, high_pf, ts_rx, ts_pecl, pll_en, refo_en;
  logic [31:0] q;
  int          error_cnt;
  int          checked;
  int          cycles;

  // ==========================================================
  // Clock, design and host
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  cmr_misc_regs dut_u (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .SCS_N_I(scs_n),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .ALIGN_EDGE_POS_I(edge_pos),
    .ALIGN_DELAY_SEL_I(dly_sel), .ALIGN_CAPTURE_DELAY_O(cap_dly),
    .FULL_SCALE_O(fs), .POWER_LOW_MODE_O(low_pw), .POWER_HIGH_PERF_O(high_pf),
    .TSTAMP_RX_EN_O(ts_rx), .TSTAMP_PECL_MODE_O(ts_pecl), .PLL_EN_I(pll_en),
    .REFCLK_OUT_EN_O(refo_en)
  );

  cmr_host_model host_u (
    .clk_i(clk), .sclk_o(sclk), .scs_n_o(scs_n), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe)
  );

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write frame, then let decoded outputs settle
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    host_u.xfer(1'b0, a, n, d, q);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [14:0] a, input int n, input logic [31:0] exp);
    host_u.xfer(1'b1, a, n, 32'h0, q);
    chk(q, exp);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset;
    chk(fs, 32'ha000);
    chk({low_pw, high_pf}, 32'h1);
    chk({ts_pecl, ts_rx}, 32'h0);
    chk(refo_en, 32'h1);
    rd_chk(cmr_pkg::ADDR_FS_LO, 2, 32'ha000);
    rd_chk(cmr_pkg::ADDR_PP1, 1, 32'h4b);
    rd_chk(cmr_pkg::ADDR_TSC, 2, 32'h0100);
  endtask

  // Status is live and ignores writes; delay select follows it
  task automatic t_position;
    edge_pos <= 24'h5a3c81;
    rd_chk(cmr_pkg::ADDR_POS_B0, 3, 32'h5a3c81);
    wr(cmr_pkg::ADDR_POS_B0, 3, 32'ha5c37e);
    rd_chk(cmr_pkg::ADDR_POS_B0, 3, 32'h5a3c81);
    dly_sel <= q[3:0];
    repeat (2) @(posedge clk);
    chk(cap_dly, 32'h1);
    for (int i = 15; i >= 0; i--)
    begin
      dly_sel <= i[3:0];
      repeat (2) @(posedge clk);
      chk(cap_dly, i);
    end
  endtask

  // Boundary codes of the recommended range, then a lone high byte
  task automatic t_full_scale;
    wr(cmr_pkg::ADDR_FS_LO, 2, 32'h2000);
    chk(fs, 32'h2000);
    wr(cmr_pkg::ADDR_FS_LO, 2, 32'hffff);
    chk(fs, 32'hffff);
    wr(cmr_pkg::ADDR_FS_HI, 1, 32'h80);
    rd_chk(cmr_pkg::ADDR_FS_LO, 2, 32'h80ff);
    chk(fs, 32'h80ff);
  endtask

  // Calibration and link are off and the rate is low in this bench
  task automatic t_profile;
    logic [7:0] code [3];
    logic [1:0] mode [3];
    code = '{8'h46, 8'h00, 8'h4b};
    mode = '{2'b10, 2'b00, 2'b01};
    for (int i = 0; i < 3; i++)
    begin
      wr(cmr_pkg::ADDR_PP1, 1, {24'h0, code[i]});
      chk({low_pw, high_pf}, mode[i]);
      rd_chk(cmr_pkg::ADDR_PP1, 1, {24'h0, code[i]});
    end
  endtask

  // Every receiver setting, reserved bits kept at zero
  task automatic t_timestamp;
    for (int i = 0; i < 4; i++)
    begin
      wr(cmr_pkg::ADDR_TSC, 1, i);
      chk({ts_pecl, ts_rx}, i);
    end
  endtask

  // Output needs both the enable bit and the synthesizer
  task automatic t_refclk;
    for (int i = 0; i < 4; i++)
    begin
      pll_en <= i[1];
      wr(cmr_pkg::ADDR_REFO, 1, i & 1);
      chk(refo_en, i == 3);
    end
    pll_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk(refo_en, 32'h0);
  endtask

  // A second reset brings every register back, output enable included
  task automatic t_mid_reset;
    wr(cmr_pkg::ADDR_FS_LO, 2, 32'h3456);
    wr(cmr_pkg::ADDR_PP1, 1, 32'h46);
    wr(cmr_pkg::ADDR_TSC, 1, 32'h3);
    wr(cmr_pkg::ADDR_REFO, 1, 32'h0);
    chk(fs, 32'h3456);
    chk({ts_pecl, ts_rx}, 32'h3);
    pll_en <= 1'b1;
    rst_n  <= 1'b0;
    repeat (3) @(posedge clk);
    chk({fs, low_pw, high_pf, refo_en}, {16'ha000, 3'b000});
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({low_pw, high_pf}, 32'h1);
    chk({ts_pecl, ts_rx}, 32'h0);
    chk(refo_en, 32'h1);
    rd_chk(cmr_pkg::ADDR_FS_LO, 2, 32'ha000);
    rd_chk(cmr_pkg::ADDR_TSC, 2, 32'h0100);
  endtask

  task automatic t_unmapped;
    wr(15'h0035, 1, 32'h5a);
    rd_chk(15'h0035, 1, 32'h0);
    chk(host_u.oe_bad, 32'h0);
  endtask

  // ==========================================================
  // Main sequence and hang guard
  // ==========================================================
  initial
  begin
    rst_n     = 1'b0;
    edge_pos  = 24'h0;
    dly_sel   = 4'h0;
    pll_en    = 1'b1;
    error_cnt = 0;
    checked   = 0;
    cycles    = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_position;
    t_full_scale;
    t_profile;
    t_timestamp;
    t_refclk;
    t_mid_reset;
    t_unmapped;
    stop_test;
  end

  // About 9100 cycles expected; cut off well beyond
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      stop_test;
    end
  end
endmodule // testbench

`default_nettype wire
